// *** logic/freq_ref_pkg.sv ***
// Constants, types and carriers for the frequency reference and ramp block.
package freq_ref_pkg;
    // Frequencies count in steps of the reference resolution (0.1 Hz or 0.01 Hz).
    typedef logic [15:0] freq_t;
    // Input fractions: 4096 is full scale (100 %).
    typedef logic [12:0] pct_t;
    typedef logic [7:0] carr_t;
    localparam freq_t PRESET_DEF = 16'h1388;
    localparam freq_t MAX_CEIL = 16'h7D00;
    localparam freq_t MAX_FLOOR_FINE = 16'h1388;
    localparam freq_t MAX_FLOOR_COARSE = 16'h01F4;
    localparam freq_t BASE_FIXED_FINE = 16'h2710;
    localparam freq_t BASE_FIXED_COARSE = 16'h03E8;
    localparam int PCT_SHIFT = 12;
    localparam pct_t PCT_FULL = 13'h1000;
    // Carrier in 0.1 kHz steps: 0.5 kHz up to 16.0 kHz.
    localparam carr_t CARR_MIN = 8'h05;
    localparam carr_t CARR_MAX = 8'hA0;
    localparam int CARR_DERATE_SHIFT = 1;
    // Base ramp time step of 0.01 s, counted in clock cycles.
    localparam int TICK_TIME_US = 10000;
    localparam int CLK_MHZ = 250;
    localparam int TICK_CYCLES_DEF = TICK_TIME_US * CLK_MHZ;
    localparam logic [6:0] UNIT_DIV_1S = 7'h64;
    localparam logic [6:0] UNIT_DIV_100MS = 7'h0A;
    localparam logic [6:0] UNIT_DIV_10MS = 7'h01;
    typedef enum logic [2:0] {SRC_DIGITAL, SRC_ANALOG1, SRC_ANALOG2, SRC_POT, SRC_PULSE,
        SRC_MULTI} main_src_e;
    typedef enum logic [1:0] {OP_SUM, OP_DIFF, OP_MAX, OP_MIN} op_e;
    typedef enum logic [2:0] {UP_DIGITAL, UP_ANALOG1, UP_ANALOG2, UP_POT, UP_PULSE} up_src_e;
    typedef enum logic [1:0] {LOW_STOP, LOW_RUN_LIMIT, LOW_ZERO} low_act_e;
    typedef enum logic [1:0] {BASE_MAX, BASE_SET, BASE_FIXED} base_e;
    typedef enum logic [1:0] {RES_COARSE = 2'h1, RES_FINE = 2'h2} res_e;
    typedef enum logic [1:0] {UNIT_1S, UNIT_100MS, UNIT_10MS} unit_e;
    typedef enum logic [1:0] {R_IDLE = 2'b00, R_ACCEL = 2'b01, R_HOLD = 2'b11,
        R_DECEL = 2'b10} ramp_e;
    typedef struct packed {freq_t accel; freq_t decel;} ramp_pair_s;
    typedef struct packed {
        pct_t first_analog_channel;
        pct_t second_analog_channel;
        pct_t pot;
        pct_t pulse_input_terminal;
        pct_t multi;
    } analog_in_s;
    typedef struct packed {
        main_src_e src;
        logic use_op;
        op_e op;
        freq_t offset;
        freq_t preset;
        freq_t max_freq;
        res_e res;
        up_src_e up_src;
        freq_t dig_upper;
        freq_t up_offset;
        freq_t lower;
        low_act_e low_act;
        base_e base_sel;
        unit_e unit;
        carr_t carrier_set;
        logic thermal_en;
        logic dir;
    } cfg_s;
endpackage : freq_ref_pkg

// *** logic/frequency_reference_ramp.sv ***
// Frequency reference combination, limiting, carrier derating and ramp generator.
// Operation
// - Max operation picks the main or auxiliary value with larger magnitude.
// - Min operation picks the main or auxiliary value with smaller magnitude.
// - With main/auxiliary operation, the offset frequency is added to the result.
// - Digital and up/down source starts from the preset frequency.
// - Direction bit 1 reverses rotation, like swapping two output phases.
// - Parameter initialisation restores the original rotation direction.
// - Analog, pulse and multi-reference full scale maps to maximum frequency.
// - Resolution selects 0.1 Hz or 0.01 Hz steps and maximum frequency range.
// - Upper-limit source: digital, two analog inputs, potentiometer or pulse input.
// - Analog upper-limit full scale maps to the digital upper limit.
// - At the upper limit the drive keeps running at that limit.
// - Digital upper limit stays between lower limit and maximum frequency.
// - Analog or pulse upper limit gets the upper-limit offset added.
// - Below lower limit: stop, run at lower limit, or zero speed.
// - Carrier frequency is kept between 0.5 kHz and 16.0 kHz.
// - Hot heatsink with thermal adjustment lowers carrier, normal restores it.
// - Acceleration time spans 0 Hz up to the ramp base frequency.
// - Deceleration time spans the ramp base frequency down to 0 Hz.
// - Four acceleration/deceleration groups, chosen by input terminals.
// - Time unit code selects 1 s, 0.1 s or 0.01 s steps.
// - Operation code 0 sums main and auxiliary, 1 takes their difference.
// - Ramp base is maximum frequency, set frequency or fixed 100 Hz.
`timescale 1ns/10ps
`default_nettype none
module frequency_reference_ramp #(
    parameter int TICK_CYCLES = freq_ref_pkg::TICK_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire freq_ref_pkg::cfg_s cfg,
    input wire freq_ref_pkg::analog_in_s ain,
    input wire logic signed [16:0] aux_freq,
    input wire freq_ref_pkg::ramp_pair_s [3:0] ramp_groups,
    input wire logic param_init,
    input wire logic dir_load,
    input wire logic run_pin,
    input wire logic up_pin,
    input wire logic down_pin,
    input wire logic hot_pin,
    input wire logic [1:0] group_pin,
    output logic [15:0] freq_out,
    output logic reverse_out,
    output logic [7:0] carrier_out,
    output logic run_out,
    output logic upper_hit
);
    // Scales an input fraction so that full scale gives the value full.
    function automatic freq_ref_pkg::freq_t scale(freq_ref_pkg::pct_t p,
        freq_ref_pkg::freq_t full);
        logic [28:0] m;
        m = 29'(p) * 29'(full);
        return (p >= freq_ref_pkg::PCT_FULL) ? full : m[freq_ref_pkg::PCT_SHIFT +: 16];
    endfunction : scale

    // Magnitude of a signed combined frequency.
    function automatic logic [17:0] mag(logic signed [17:0] v);
        return v[17] ? 18'(-v) : 18'(v);
    endfunction : mag

    function automatic freq_ref_pkg::freq_t fmin(freq_ref_pkg::freq_t a,
        freq_ref_pkg::freq_t b);
        return (a < b) ? a : b;
    endfunction : fmin

    // Pins pass two flip-flops before any logic looks at them.
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [5:0] pin_prev;
    logic run_s;
    logic hot_s;
    logic [1:0] grp;
    logic up_edge;
    logic down_edge;
    assign run_s = pin_sync[5];
    assign hot_s = pin_sync[2];
    assign grp = pin_sync[1:0];
    assign up_edge = pin_sync[4] & ~pin_prev[4];
    assign down_edge = pin_sync[3] & ~pin_prev[3];

    // Reference path, all combinational; the digital value is a register declared here.
    freq_ref_pkg::freq_t dig_freq;
    freq_ref_pkg::freq_t max_eff, floor_f, main_f, ref_f, dig_up, upper, lower, tgt;
    logic signed [17:0] x, y, op_res, comb;
    logic [17:0] m_comb;
    logic [16:0] up_sum;
    logic hit_c, stop_c, neg_c;
    always_comb
    begin
        floor_f = (cfg.res == freq_ref_pkg::RES_COARSE) ? freq_ref_pkg::MAX_FLOOR_COARSE
            : freq_ref_pkg::MAX_FLOOR_FINE;
        max_eff = cfg.max_freq;
        if (max_eff < floor_f) max_eff = floor_f;
        if (max_eff > freq_ref_pkg::MAX_CEIL) max_eff = freq_ref_pkg::MAX_CEIL;
        case (cfg.src)
            freq_ref_pkg::SRC_ANALOG1: main_f = scale(ain.first_analog_channel, max_eff);
            freq_ref_pkg::SRC_ANALOG2: main_f = scale(ain.second_analog_channel, max_eff);
            freq_ref_pkg::SRC_POT: main_f = scale(ain.pot, max_eff);
            freq_ref_pkg::SRC_PULSE: main_f = scale(ain.pulse_input_terminal, max_eff);
            freq_ref_pkg::SRC_MULTI: main_f = scale(ain.multi, max_eff);
            default: main_f = fmin(dig_freq, max_eff);
        endcase
        x = signed'(18'(main_f));
        y = {aux_freq[16], aux_freq};
        case (cfg.op)
            freq_ref_pkg::OP_DIFF: op_res = x - y;
            freq_ref_pkg::OP_MAX: op_res = (mag(x) >= mag(y)) ? x : y;
            freq_ref_pkg::OP_MIN: op_res = (mag(x) <= mag(y)) ? x : y;
            default: op_res = x + y;
        endcase
        comb = cfg.use_op ? op_res + signed'(18'(cfg.offset)) : x;
        neg_c = comb[17];
        m_comb = mag(comb);
        ref_f = (m_comb > 18'(max_eff)) ? max_eff : m_comb[15:0];
        dig_up = cfg.dig_upper;
        if (dig_up < cfg.lower) dig_up = cfg.lower;
        dig_up = fmin(dig_up, max_eff);
        case (cfg.up_src)
            freq_ref_pkg::UP_ANALOG1: up_sum = 17'(scale(ain.first_analog_channel, dig_up))
                + 17'(cfg.up_offset);
            freq_ref_pkg::UP_ANALOG2: up_sum = 17'(scale(ain.second_analog_channel, dig_up))
                + 17'(cfg.up_offset);
            freq_ref_pkg::UP_POT: up_sum = 17'(scale(ain.pot, dig_up))
                + 17'(cfg.up_offset);
            freq_ref_pkg::UP_PULSE: up_sum = 17'(scale(ain.pulse_input_terminal, max_eff))
                + 17'(cfg.up_offset);
            default: up_sum = 17'(dig_up);
        endcase
        upper = (up_sum > 17'(max_eff)) ? max_eff : up_sum[15:0];
        lower = fmin(cfg.lower, upper);
        hit_c = 1'b0;
        stop_c = 1'b0;
        tgt = ref_f;
        if (ref_f > upper)
        begin
            tgt = upper;
            hit_c = 1'b1;
        end
        else if (ref_f < lower)
        begin
            case (cfg.low_act)
                freq_ref_pkg::LOW_STOP:
                begin
                    tgt = '0;
                    stop_c = 1'b1;
                end
                freq_ref_pkg::LOW_RUN_LIMIT: tgt = lower;
                default: tgt = '0;
            endcase
        end
    end

    // Ramp, direction, carrier and divider state.
    freq_ref_pkg::ramp_e ramp_st, next_ramp;
    freq_ref_pkg::freq_t next_dig, next_freq, goal, base, tm;
    freq_ref_pkg::carr_t carr, next_carrier;
    logic [31:0] acc, next_acc, tick_cnt, next_tick;
    logic [6:0] unit_cnt, next_unit, unit_div;
    logic dir, next_dir, next_reverse, run_req, rev_req, tick, unit_tick;
    always_comb
    begin
        tick = (tick_cnt == 32'(TICK_CYCLES - 1));
        next_tick = tick ? '0 : tick_cnt + 32'h0000_0001;
        case (cfg.unit)
            freq_ref_pkg::UNIT_1S: unit_div = freq_ref_pkg::UNIT_DIV_1S;
            freq_ref_pkg::UNIT_10MS: unit_div = freq_ref_pkg::UNIT_DIV_10MS;
            default: unit_div = freq_ref_pkg::UNIT_DIV_100MS;
        endcase
        unit_tick = tick && (unit_cnt >= unit_div - 7'h01);
        next_unit = tick ? (unit_tick ? '0 : unit_cnt + 7'h01) : unit_cnt;
        next_dig = dig_freq;
        if (!run_s) next_dig = cfg.preset;
        else if (up_edge && dig_freq < max_eff) next_dig = dig_freq + 16'h0001;
        else if (down_edge && dig_freq != '0) next_dig = dig_freq - 16'h0001;
        next_dir = param_init ? 1'b0 : (dir_load ? cfg.dir : dir);
        rev_req = dir ^ neg_c;
        run_req = run_s & ~stop_c;
        next_reverse = (freq_out == '0 && run_req) ? rev_req : reverse_out;
        // A reversal first ramps down to zero before the phase order swaps.
        goal = (!run_req || (rev_req != reverse_out && freq_out != '0)) ? '0 : tgt;
        case (cfg.base_sel)
            freq_ref_pkg::BASE_SET: base = tgt;
            freq_ref_pkg::BASE_FIXED: base = (cfg.res == freq_ref_pkg::RES_COARSE)
                ? freq_ref_pkg::BASE_FIXED_COARSE : freq_ref_pkg::BASE_FIXED_FINE;
            default: base = max_eff;
        endcase
        if (freq_out < goal) next_ramp = freq_ref_pkg::R_ACCEL;
        else if (freq_out > goal) next_ramp = freq_ref_pkg::R_DECEL;
        else next_ramp = (goal == '0) ? freq_ref_pkg::R_IDLE : freq_ref_pkg::R_HOLD;
        tm = (next_ramp == freq_ref_pkg::R_ACCEL) ? ramp_groups[grp].accel
            : ramp_groups[grp].decel;
        next_freq = freq_out;
        next_acc = '0;
        if (next_ramp == freq_ref_pkg::R_ACCEL || next_ramp == freq_ref_pkg::R_DECEL)
        begin
            // Each time unit adds base to the accumulator; each time-worth is one step.
            if (tm == '0) next_freq = goal;
            else
            begin
                next_acc = acc + (unit_tick ? 32'(base) : 32'h0000_0000);
                if (acc >= 32'(tm))
                begin
                    next_acc = next_acc - 32'(tm);
                    next_freq = (next_ramp == freq_ref_pkg::R_ACCEL) ? freq_out + 16'h0001
                        : freq_out - 16'h0001;
                end
            end
        end
        carr = cfg.carrier_set;
        if (carr < freq_ref_pkg::CARR_MIN) carr = freq_ref_pkg::CARR_MIN;
        if (carr > freq_ref_pkg::CARR_MAX) carr = freq_ref_pkg::CARR_MAX;
        next_carrier = carr;
        if (cfg.thermal_en && hot_s)
            next_carrier = ((carr >> freq_ref_pkg::CARR_DERATE_SHIFT) < freq_ref_pkg::CARR_MIN)
                ? freq_ref_pkg::CARR_MIN : (carr >> freq_ref_pkg::CARR_DERATE_SHIFT);
    end

    // Registers for all state of the block.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
            ramp_st <= freq_ref_pkg::R_IDLE;
            dig_freq <= freq_ref_pkg::PRESET_DEF;
            acc <= '0;
            tick_cnt <= '0;
            unit_cnt <= '0;
            dir <= 1'b0;
            freq_out <= '0;
            reverse_out <= 1'b0;
            carrier_out <= freq_ref_pkg::CARR_MIN;
            run_out <= 1'b0;
            upper_hit <= 1'b0;
        end
        else
        begin
            pin_meta <= {run_pin, up_pin, down_pin, hot_pin, group_pin};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            ramp_st <= next_ramp;
            dig_freq <= next_dig;
            acc <= next_acc;
            tick_cnt <= next_tick;
            unit_cnt <= next_unit;
            dir <= next_dir;
            freq_out <= next_freq;
            reverse_out <= next_reverse;
            carrier_out <= next_carrier;
            run_out <= run_req || (freq_out != '0);
            upper_hit <= hit_c & run_req;
        end
    end

    // Checks on the reference path, limits, carrier and ramp.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_max_pick: assert property (
        cfg.use_op && cfg.op == freq_ref_pkg::OP_MAX |->
        mag(op_res) >= mag(x) && mag(op_res) >= mag(y)) else $error("max pick wrong");
    a_min_pick: assert property (
        cfg.use_op && cfg.op == freq_ref_pkg::OP_MIN |->
        mag(op_res) <= mag(x) && mag(op_res) <= mag(y)) else $error("min pick wrong");
    a_preset_load: assert property (
        !run_s |=> dig_freq == $past(cfg.preset))
        else $error("preset not loaded");
    // The phase order only returns once the output has come down to zero while running.
    a_dir_revert: assert property (
        param_init |=> !dir ##1 (!reverse_out || $past(freq_out) != '0 || !$past(run_req)
        || $past(neg_c)))
        else $error("direction not restored");
    a_reverse_safe: assert property (
        $changed(reverse_out) |-> $past(freq_out) == '0)
        else $error("phase order swapped while turning");
    a_max_range: assert property (
        max_eff >= floor_f && max_eff <= freq_ref_pkg::MAX_CEIL)
        else $error("maximum frequency out of range");
    a_upper_cap: assert property (
        tgt <= upper && upper <= max_eff)
        else $error("target above upper limit");
    a_lower_stop: assert property (
        ref_f < lower && ref_f <= upper &&
        cfg.low_act == freq_ref_pkg::LOW_STOP |-> tgt == '0 && !run_req)
        else $error("lower limit stop missed");
    a_carrier_range: assert property (
        carrier_out >= freq_ref_pkg::CARR_MIN && carrier_out <= freq_ref_pkg::CARR_MAX)
        else $error("carrier out of range");
    a_carrier_derate: assert property (
        cfg.thermal_en && hot_s |=> carrier_out <= $past(carr)
        && (carrier_out < $past(carr) || $past(carr) == freq_ref_pkg::CARR_MIN))
        else $error("carrier not derated");
    a_carrier_restore: assert property (
        !(cfg.thermal_en && hot_s) |=> carrier_out == $past(carr))
        else $error("carrier not restored");
    a_ramp_linear: assert property (
        $past(tm) != '0 |-> freq_out - $past(freq_out) == 16'h0000
        || freq_out - $past(freq_out) == 16'h0001 || $past(freq_out) - freq_out == 16'h0001)
        else $error("ramp step larger than one");
    c_accel: cover property (ramp_st == freq_ref_pkg::R_ACCEL ##1 ramp_st == freq_ref_pkg::R_HOLD);
    c_decel: cover property (ramp_st == freq_ref_pkg::R_DECEL ##1 ramp_st == freq_ref_pkg::R_IDLE);
    c_upper: cover property (upper_hit && ramp_st == freq_ref_pkg::R_HOLD);
    c_derate: cover property (cfg.thermal_en && hot_s ##1 carrier_out < cfg.carrier_set);
endmodule : frequency_reference_ramp
`default_nettype wire

// *** test/term_model.sv ***
// Behavioural model of the drive terminals, keypad and analog inputs.
`timescale 1ns/10ps
`default_nettype none
module term_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic [5:0] want,
    input wire freq_ref_pkg::analog_in_s want_ain,
    output logic run_pin,
    output logic hot_pin,
    output logic [1:0] group_pin,
    output logic up_pin,
    output logic down_pin,
    output var freq_ref_pkg::analog_in_s ain
);
    logic [5:0] pipe [0:7];

    // Levels are taken on the rising edge, after the bench set them at the falling edge,
    // so the model never races the bench; a slow terminal lags eight cycles behind.
    always @(posedge clk)
    begin
        pipe[0] <= want;
        for (int i = 1; i < 8; i++)
        begin
            pipe[i] <= pipe[i - 1];
        end
        {run_pin, hot_pin, group_pin, up_pin, down_pin} <= slow ? pipe[7] : want;
        ain <= want_ain;
    end
endmodule : term_model
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the frequency reference and ramp block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct {string what; logic [15:0] exp; logic [15:0] tol;} note_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    freq_ref_pkg::cfg_s cfg;
    freq_ref_pkg::analog_in_s want_ain, ain;
    freq_ref_pkg::ramp_pair_s [3:0] ramp_groups;
    logic signed [16:0] aux_freq;
    logic param_init, dir_load, slow, want_run, want_hot, press_up, press_down;
    logic run_pin, up_pin, down_pin, hot_pin, reverse_out, run_out, upper_hit;
    logic [1:0] want_group, group_pin;
    logic [15:0] freq_out, seen;
    logic [7:0] carrier_out;
    logic [19:0] lfsr = 20'h16685;
    int bad_count = 0;
    int samples_checked = 0;
    int a, m, e;
    logic neg;
    note_s notes[$];
    note_s n;
    event look;
    int ex [4] = '{16'h0834, 16'h044C, 16'h0BB8, 16'h0A28};
    logic [15:0] rt [5] = '{16'h1388, 16'h09C4, 16'h1388, 16'h1388, 16'h01F4};
    int ru [5] = '{2, 2, 2, 1, 0};
    int rb [5] = '{0, 0, 2, 0, 0};
    int rx [5] = '{50, 100, 100, 5, 25};

    always #2 clk = ~clk;

    frequency_reference_ramp #(.TICK_CYCLES(4)) dut (.clk(clk), .nrst(nrst), .cfg(cfg),
        .ain(ain), .aux_freq(aux_freq), .ramp_groups(ramp_groups), .param_init(param_init),
        .dir_load(dir_load), .run_pin(run_pin), .up_pin(up_pin), .down_pin(down_pin),
        .hot_pin(hot_pin), .group_pin(group_pin), .freq_out(freq_out),
        .reverse_out(reverse_out), .carrier_out(carrier_out), .run_out(run_out),
        .upper_hit(upper_hit));

    term_model far (.clk(clk), .slow(slow), .want_ain(want_ain), .ain(ain),
        .want({want_run, want_hot, want_group, press_up, press_down}), .run_pin(run_pin),
        .hot_pin(hot_pin), .group_pin(group_pin), .up_pin(up_pin), .down_pin(down_pin));

    function automatic logic [19:0] step_lfsr(input logic [19:0] s);
        return {s[18:0], s[19] ^ s[16]};
    endfunction : step_lfsr

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic note(input string what, input logic [15:0] exp, input logic [15:0] tol = 0);
        notes.push_back('{what, exp, tol});
        -> look;
    endtask : note

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    // Drops and raises the run command so the digital value reloads from the preset.
    task automatic settle();
        want_run = 1'b0;
        cyc(8);
        want_run = 1'b1;
        cyc(10);
    endtask : settle

    task automatic print_verdict();
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // Takes every queued expectation, oldest first, and compares each with the output that it names.
    always @(look)
    begin
        while (notes.size() > 0)
        begin
            n = notes.pop_front();
            case (n.what)
                "carrier_out": seen = {8'h00, carrier_out};
                "reverse_out": seen = {15'h0000, reverse_out};
                "upper_hit": seen = {15'h0000, upper_hit};
                "run_out": seen = {15'h0000, run_out};
                default: seen = freq_out;
            endcase
            if (n.tol == 0)
                check(n.what, seen, n.exp);
            else
                check("freq window", {15'h0, seen + n.tol >= n.exp && seen <= n.exp + n.tol}, 1);
        end
    end

    // A hang is cut short well beyond the expected run length.
    initial
    begin
        #100000;
        bad_count++;
        print_verdict();
    end

    initial
    begin
        cfg = '0;
        cfg.src = freq_ref_pkg::SRC_DIGITAL;
        cfg.preset = 16'h0BB8;
        cfg.max_freq = 16'h4E20;
        cfg.res = freq_ref_pkg::RES_FINE;
        cfg.dig_upper = 16'h4E20;
        cfg.carrier_set = 8'h64;
        cfg.thermal_en = 1'b1;
        cfg.unit = freq_ref_pkg::UNIT_10MS;
        cfg.low_act = freq_ref_pkg::LOW_RUN_LIMIT;
        want_ain = '{13'h0800, 13'h0400, 13'h0C00, 13'h0200, 13'h0400};
        ramp_groups = '0;
        aux_freq = '0;
        {param_init, dir_load, slow, want_run, want_hot, press_up, press_down} = 7'h00;
        want_group = 2'h0;
        cyc(4);
        note("freq_out", 16'h0000);
        note("carrier_out", 16'h0005);
        note("reverse_out", 16'h0000);
        note("upper_hit", 16'h0000);
        note("run_out", 16'h0000);
        nrst = 1'b1;
        cyc(8);
        note("carrier_out", 16'h0064);
        want_hot = 1'b1;
        cyc(8);
        note("carrier_out", 16'h0032);
        cfg.thermal_en = 1'b0;
        cyc(4);
        note("carrier_out", 16'h0064);
        cfg.carrier_set = 8'hC8;
        cyc(4);
        note("carrier_out", 16'h00A0);
        cfg.carrier_set = 8'h02;
        cyc(4);
        note("carrier_out", 16'h0005);
        {want_hot, cfg.thermal_en, cfg.carrier_set} = {2'b01, 8'h64};
        settle();
        note("freq_out", 16'h0BB8);
        for (int i = 0; i < 3; i++)
        begin
            {press_up, press_down} = (i < 2) ? 2'b10 : 2'b01;
            cyc(5);
            {press_up, press_down} = 2'b00;
            cyc(5);
        end
        note("freq_out", 16'h0BB9);
        cfg.use_op = 1'b1;
        for (int k = 0; k < 16; k++)
        begin
            lfsr = step_lfsr(lfsr);
            a = lfsr[11:0];
            neg = lfsr[12] && k % 4 > 1;
            m = (k % 4 == 1 || (neg && k % 4 == 2)) ? a % 2048 : (neg ? a + 3001 : a);
            e = k % 4 == 0 ? 3000 + m : k % 4 == 1 ? 3000 - m : neg ? 3000 :
                k % 4 == 2 ? (m > 3000 ? m : 3000) : (m < 3000 ? m : 3000);
            aux_freq = 17'(neg ? -m : m);
            cfg.offset = {8'h00, lfsr[19:12]};
            cfg.op = freq_ref_pkg::op_e'(k % 4);
            settle();
            note("freq_out", 16'(e + lfsr[19:12]));
        end
        {aux_freq, cfg.offset, cfg.op, cfg.dig_upper} = {17'h0, 16'h0, 2'h0, 16'h09C4};
        settle();
        note("freq_out", 16'h09C4);
        note("upper_hit", 16'h0001);
        {cfg.preset, cfg.dig_upper} = {16'h61A8, 16'h7530};
        settle();
        note("freq_out", 16'h4E20);
        {cfg.preset, cfg.dig_upper, cfg.up_offset} = {16'h0BB8, 16'h0FA0, 16'h0064};
        for (int k = 1; k < 5; k++)
        begin
            cfg.up_src = freq_ref_pkg::up_src_e'(k);
            settle();
            note("freq_out", 16'(ex[k - 1]));
        end
        {cfg.up_src, cfg.use_op, cfg.dig_upper} = {3'h0, 1'b0, 16'h4E20};
        for (int k = 1; k < 6; k++)
        begin
            cfg.src = freq_ref_pkg::main_src_e'(k);
            settle();
            note("freq_out", k == 1 ? 16'h2710 : k == 2 ? 16'h1388 : k == 3 ? 16'h3A98 :
                k == 4 ? 16'h09C4 : 16'h1388);
        end
        // Coarse steps raise a too small maximum frequency to its lower bound.
        {cfg.src, cfg.res, cfg.max_freq} = {3'h1, 2'h1, 16'h012C};
        settle();
        note("freq_out", 16'h00FA);
        {cfg.src, cfg.res, cfg.max_freq, cfg.preset, cfg.lower} =
            {3'h0, 2'h2, 16'h4E20, 16'h03E8, 16'h05DC};
        for (int k = 0; k < 3; k++)
        begin
            cfg.low_act = freq_ref_pkg::low_act_e'(k);
            settle();
            note("freq_out", k == 1 ? 16'h05DC : 16'h0000);
            note("run_out", k == 0 ? 16'h0000 : 16'h0001);
        end
        {cfg.lower, want_run, cfg.dir, dir_load} = {16'h0000, 3'b111};
        cyc(1);
        dir_load = 1'b0;
        cyc(6);
        note("reverse_out", 16'h0001);
        slow = 1'b1;
        want_run = 1'b1;
        cyc(20);
        param_init = 1'b1;
        cyc(1);
        param_init = 1'b0;
        cyc(10);
        note("reverse_out", 16'h0000);
        note("freq_out", 16'h03E8);
        {slow, cfg.preset, cfg.max_freq, cfg.dig_upper} = {1'b0, 16'h0190, 16'h1388, 16'h1388};
        for (int i = 0; i < 5; i++)
        begin
            ramp_groups = '0;
            want_run = 1'b0;
            cyc(6);
            ramp_groups[i % 4] = '{rt[i], rt[i]};
            cfg.unit = freq_ref_pkg::unit_e'(ru[i]);
            cfg.base_sel = freq_ref_pkg::base_e'(rb[i]);
            want_group = 2'(i);
            cyc(8);
            want_run = 1'b1;
            cyc(ru[i] == 0 ? 1004 : 204);
            note("freq_out", 16'(rx[i]), 16'(rx[i] / 8 + 3));
            if (i == 0)
            begin
                cyc(1500);
                note("freq_out", 16'h0190);
                want_run = 1'b0;
                cyc(200);
                note("freq_out", 16'h015E, 16'h0009);
            end
        end
        cyc(2);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
